// ---- cgc_clock_regs.vh ----
// Purpose: Offsets, field positions, reset values and AHB transfer types for the clock control block.
// Assumes: Byte addresses within the block's 64 KB window on the system bus.
// Notes: Included by the clock control module only.
`ifndef CGC_CLOCK_REGS_VH
`define CGC_CLOCK_REGS_VH

// Register byte offsets.
`define CGC_OFF_OSC_CTRL 16'h0400
`define CGC_OFF_UNIT_GATES 16'h0404

// Oscillator control fields and reset value.
`define CGC_OSC_PLL_STABLE_BIT 0
`define CGC_OSC_PLL_EN_BIT 1
`define CGC_OSC_RING_EN_BIT 2
`define CGC_OSC_CTRL_RESET 8'h06

// Unit clock gate fields and reset value.
`define CGC_GATE_CARD_ONE_BIT 3
`define CGC_GATE_CARD_TWO_BIT 4
`define CGC_GATE_USB_BIT 7
`define CGC_GATE_UART_BIT 8
`define CGC_GATE_SMARTCARD_BIT 9
`define CGC_GATE_SERIAL_BIT 10
`define CGC_GATE_AES_BIT 11
`define CGC_GATE_FLASH_BIT 12
`define CGC_GATE_SRAM_BIT 13
`define CGC_GATE_TIMER_BIT 14
`define CGC_GATE_WRITABLE 32'h0000_7F98
`define CGC_UNIT_GATES_RESET 32'h0000_0000

// AHB transfer types that carry a request.
`define CGC_HTRANS_NONSEQ 2'h2
`define CGC_HTRANS_SEQ 2'h3

`endif

// ---- cgc_clock_control.v ----
// Purpose: Clock control register block: ring oscillator and PLL enables, PLL stable status,
//   system clock source select and glitch-free clock gates for ten peripheral units.
// Assumes: AHB-lite slave on the system clock; wake-up and PLL lock inputs are asynchronous.
// Notes: Zero wait states, always OKAY; unmapped addresses read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "cgc_clock_regs.vh"

module cgc_clock_control #(
  parameter NUM_UNITS = 10
) (
  input wire clk,
  input wire rstn,
  input wire hsel,
  input wire [15:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hready_out,
  output wire hresp,
  input wire wake_event,
  input wire usb_wake_event,
  input wire usb_engine_power_enable,
  input wire pll_lock,
  output wire ring_osc_enable,
  output wire pll_enable,
  output wire sys_clk_select_pll,
  output wire [NUM_UNITS-1:0] unit_clk,
  output wire [NUM_UNITS-1:0] unit_low_power,
  output wire usb_phy_power_down,
  output reg usb_ctrl_reset
);

  // Registers and status.
  reg ring_osc_en;
  reg pll_en;
  reg [31:0] unit_clock_gates;
  reg [1:0] wake_sync;
  reg [1:0] usb_wake_sync;
  reg [1:0] lock_sync;
  reg usb_gate_seen;
  reg data_write;
  reg [15:0] data_addr;
  reg [NUM_UNITS-1:0] gate_latched;
  wire wake_now;
  wire usb_wake_now;
  wire pll_stable;
  wire req;
  wire [7:0] osc_ctrl_value;
  wire [NUM_UNITS-1:0] gate_bits;
  reg [31:0] next_hrdata;

  // Reset image of the oscillator control register, so single fields can be picked out.
  localparam [7:0] OSC_RESET = `CGC_OSC_CTRL_RESET;

  // Returns one when the address selects the given register.
  function hits;
    input [15:0] addr;
    input [15:0] offset;
    begin
      hits = (addr == offset);
    end
  endfunction

  // Two-flop synchronisers for the asynchronous wake-up and lock inputs.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wake_sync <= 2'h0;
      usb_wake_sync <= 2'h0;
      lock_sync <= 2'h0;
    end else begin
      wake_sync <= {wake_sync[0], wake_event};
      usb_wake_sync <= {usb_wake_sync[0], usb_wake_event};
      lock_sync <= {lock_sync[0], pll_lock};
    end
  end

  // A USB resume counts only while the USB engine clock and power are on.
  assign usb_wake_now = usb_wake_sync[1] & usb_engine_power_enable &
    unit_clock_gates[`CGC_GATE_USB_BIT];
  // Any wake-up event, USB or not, wakes the ring oscillator.
  assign wake_now = wake_sync[1] | usb_wake_sync[1];

  // AHB address phase: a valid request while the bus is ready.
  assign req = hsel & hready & (htrans == `CGC_HTRANS_NONSEQ | htrans == `CGC_HTRANS_SEQ);
  assign hready_out = 1'b1;
  assign hresp = 1'b0;

  // Capture the address phase of a write for the following data phase.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      data_write <= 1'b0;
      data_addr <= 16'h0000;
    end else begin
      data_write <= req & hwrite;
      data_addr <= haddr;
    end
  end

  // Oscillator enables; hardware set wins over a firmware clear.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ring_osc_en <= OSC_RESET[`CGC_OSC_RING_EN_BIT];
      pll_en <= OSC_RESET[`CGC_OSC_PLL_EN_BIT];
    end else begin
      if (data_write && hits(data_addr, `CGC_OFF_OSC_CTRL)) begin
        ring_osc_en <= hwdata[`CGC_OSC_RING_EN_BIT] | wake_now;
        // A running PLL is kept on while any wake-up is active; only a USB wake starts it.
        pll_en <= hwdata[`CGC_OSC_PLL_EN_BIT] | usb_wake_now | (pll_en & wake_now);
      end else begin
        ring_osc_en <= ring_osc_en | wake_now;
        pll_en <= pll_en | usb_wake_now;
      end
    end
  end

  // Unit gates; only documented bits are writable.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      unit_clock_gates <= `CGC_UNIT_GATES_RESET;
    end else if (data_write && hits(data_addr, `CGC_OFF_UNIT_GATES)) begin
      unit_clock_gates <= hwdata & `CGC_GATE_WRITABLE;
    end
  end

  // One-cycle reset pulse to the USB controller on the first enable after reset.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      usb_gate_seen <= 1'b0;
      usb_ctrl_reset <= 1'b0;
    end else begin
      usb_ctrl_reset <= unit_clock_gates[`CGC_GATE_USB_BIT] & ~usb_gate_seen;
      if (unit_clock_gates[`CGC_GATE_USB_BIT]) begin
        usb_gate_seen <= 1'b1;
      end
    end
  end

  // PLL is stable only while enabled and locked; then it drives the system clock.
  assign pll_stable = pll_en & lock_sync[1];
  assign sys_clk_select_pll = pll_stable;
  assign ring_osc_enable = ring_osc_en;
  assign pll_enable = pll_en;
  assign usb_phy_power_down = ~unit_clock_gates[`CGC_GATE_USB_BIT];

  // Read data is prepared in the address phase and held in a flop for the data phase.
  assign osc_ctrl_value = {5'h00, ring_osc_en, pll_en, pll_stable};
  always @* begin
    next_hrdata = 32'h0000_0000;
    if (hits(haddr, `CGC_OFF_OSC_CTRL)) begin
      next_hrdata = {24'h00_0000, osc_ctrl_value};
    end else if (hits(haddr, `CGC_OFF_UNIT_GATES)) begin
      next_hrdata = unit_clock_gates;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h0000_0000;
    end else if (req && !hwrite) begin
      hrdata <= next_hrdata;
    end
  end

  // Gate bit order: card one, card two, USB, UART, smart card, serial, AES, flash, SRAM, timer.
  assign gate_bits = {
    unit_clock_gates[`CGC_GATE_TIMER_BIT],
    unit_clock_gates[`CGC_GATE_SRAM_BIT],
    unit_clock_gates[`CGC_GATE_FLASH_BIT],
    unit_clock_gates[`CGC_GATE_AES_BIT],
    unit_clock_gates[`CGC_GATE_SERIAL_BIT],
    unit_clock_gates[`CGC_GATE_SMARTCARD_BIT],
    unit_clock_gates[`CGC_GATE_UART_BIT],
    unit_clock_gates[`CGC_GATE_USB_BIT],
    unit_clock_gates[`CGC_GATE_CARD_TWO_BIT],
    unit_clock_gates[`CGC_GATE_CARD_ONE_BIT]
  };

  // Enables change only while the clock is low, so each gated clock has whole pulses.
  genvar g;
  generate
    for (g = 0; g < NUM_UNITS; g = g + 1) begin : gen_gate
      always @(negedge clk or negedge rstn) begin
        if (!rstn) begin
          gate_latched[g] <= 1'b0;
        end else begin
          gate_latched[g] <= gate_bits[g];
        end
      end
      assign unit_clk[g] = clk & gate_latched[g];
      assign unit_low_power[g] = ~gate_bits[g];
    end
  endgenerate

endmodule // cgc_clock_control
`default_nettype wire

// ---- cgc_clock_control_assertions.sv ----
// Purpose: Port checks for the clock control block.
// Assumes: Sees top ports only.
// Notes: Bound to every instance.
`timescale 1ns/1ps
`default_nettype none
module cgc_clock_control_assertions (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [31:0] hrdata,
  input wire logic wake_event,
  input wire logic usb_wake_event,
  input wire logic usb_engine_power_enable,
  input wire logic pll_lock,
  input wire logic ring_osc_enable,
  input wire logic pll_enable,
  input wire logic sys_clk_select_pll,
  input wire logic [9:0] unit_low_power,
  input wire logic usb_phy_power_down,
  input wire logic usb_ctrl_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Wake inputs pass a two-flop sync, so four samples cover the delay.
  property p_wake_ro; wake_event [*4] |-> ring_osc_enable; endproperty
  a_wake_ro: assert property (p_wake_ro) else $error("ring osc not forced");
  property p_usb_ro; usb_wake_event [*4] |-> ring_osc_enable; endproperty
  a_usb_ro: assert property (p_usb_ro) else $error("ring osc dropped");
  property p_pll_hold; wake_event [*3] ##0 pll_enable |=> pll_enable; endproperty
  a_pll_hold: assert property (p_pll_hold) else $error("pll dropped in wake");
  property p_usb_pll;
    (usb_wake_event && usb_engine_power_enable && !usb_phy_power_down) [*4] |-> pll_enable;
  endproperty
  a_usb_pll: assert property (p_usb_pll) else $error("pll not woken");
  property p_sel; (pll_enable && pll_lock) [*4] |-> sys_clk_select_pll; endproperty
  a_sel: assert property (p_sel) else $error("pll not selected");
  property p_sel_off; sys_clk_select_pll |-> pll_enable; endproperty
  a_sel_off: assert property (p_sel_off) else $error("off pll selected");
  property p_phy; usb_phy_power_down == unit_low_power[2]; endproperty
  a_phy: assert property (p_phy) else $error("phy state wrong");
  property p_rst; usb_ctrl_reset |-> !usb_phy_power_down ##1 !usb_ctrl_reset; endproperty
  a_rst: assert property (p_rst) else $error("bad usb reset");
  property p_rsvd; (hrdata & 32'hFFFF_8060) == 32'h0000_0000; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  c_rst: cover property (usb_ctrl_reset);
  c_sel: cover property (sys_clk_select_pll);
  c_wake: cover property (wake_event && ring_osc_enable);
endmodule // cgc_clock_control_assertions
bind cgc_clock_control cgc_clock_control_assertions u_chk (.*);
`default_nettype wire

// ---- cgc_clock_control_bench.sv ----
// Purpose: Self-checking bench for the clock control block.
// Assumes: Inputs change at the falling edge.
// Notes: Registers reached over the bus port.
`timescale 1ns/1ps
`default_nettype none
module cgc_clock_control_bench;
  logic clk = 0, rstn = 0, hsel = 0, hwrite = 0, hready = 1, pll_lock = 0;
  logic wake_event = 0, usb_wake_event = 0, usb_engine_power_enable = 0;
  logic [15:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 0, hrdata;
  logic hready_out, hresp, ring_osc_enable, pll_enable, sys_clk_select_pll;
  logic usb_phy_power_down, usb_ctrl_reset;
  logic [9:0] unit_clk, unit_low_power;
  int num_errors = 0, checks = 0, pulses = 0, cycles = 0;
  int bits[10] = '{3, 4, 7, 8, 9, 10, 11, 12, 13, 14};
  cgc_clock_control dut (.*);
  always #12.5 clk = ~clk;
  // Counts controller reset pulses and cuts a hang short.
  always @(posedge clk) begin
    pulses <= pulses + usb_ctrl_reset;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      print_verdict();
    end
  end
  task print_verdict;
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task w(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Address phase, then data phase with the request dropped.
  task wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge clk);
    {hsel, htrans, hwrite, haddr} = {1'b1, 2'h2, 1'b1, a};
    @(negedge clk);
    {hsel, htrans, hwdata} = {1'b0, 2'h0, d};
  endtask
  task rd(input logic [15:0] a, input logic [31:0] e);
    @(negedge clk);
    {hsel, htrans, hwrite, haddr} = {1'b1, 2'h2, 1'b0, a};
    @(negedge clk);
    {hsel, htrans} = 3'h0;
    chk(hrdata, e);
  endtask
  // Main sequence of tests.
  initial begin
    w(20);
    rstn = 1;
    rd(16'h0400, 32'h0000_0006);
    rd(16'h0404, 32'h0000_0000);
    chk({22'h0, unit_low_power}, 32'h0000_03FF);
    chk({hresp, hready_out, usb_phy_power_down, ring_osc_enable, pll_enable}, 32'h0000_000F);
    $display("reset test done");
    foreach (bits[i]) begin
      wr(16'h0404, 32'h0000_0001 << bits[i]);
      repeat (2) @(posedge clk);
      #5 chk({22'h0, unit_clk}, 32'h0000_0001 << i);
      chk({22'h0, ~unit_low_power}, 32'h0000_0001 << i);
    end
    wr(16'h0404, 32'hFFFF_FFFF);
    rd(16'h0404, 32'h0000_7F98);
    chk(pulses, 32'h0000_0001);
    wr(16'h0408, 32'hFFFF_FFFF);
    rd(16'h0408, 32'h0000_0000);
    $display("gate test done");
    pll_lock = 1;
    w(4);
    rd(16'h0400, 32'h0000_0007);
    chk(sys_clk_select_pll, 32'h0000_0001);
    wr(16'h0400, 32'h0000_0004);
    rd(16'h0400, 32'h0000_0004);
    chk({ring_osc_enable, pll_enable, sys_clk_select_pll}, 32'h0000_0004);
    wr(16'h0400, 32'h0000_0002);
    rd(16'h0400, 32'h0000_0003);
    wake_event = 1;
    w(4);
    wr(16'h0400, 32'h0000_0000);
    rd(16'h0400, 32'h0000_0007);
    wake_event = 0;
    w(3);
    wr(16'h0400, 32'h0000_0000);
    rd(16'h0400, 32'h0000_0000);
    $display("wake test done");
    usb_wake_event = 1;
    w(4);
    rd(16'h0400, 32'h0000_0004);
    usb_engine_power_enable = 1;
    w(4);
    rd(16'h0400, 32'h0000_0007);
    usb_wake_event = 0;
    w(3);
    wr(16'h0400, 32'h0000_0000);
    wr(16'h0404, 32'h0000_0000);
    usb_wake_event = 1;
    w(4);
    rd(16'h0400, 32'h0000_0004);
    usb_wake_event = 0;
    wr(16'h0404, 32'h0000_0080);
    w(3);
    chk(pulses, 32'h0000_0001);
    $display("usb test done");
    print_verdict();
  end
endmodule // cgc_clock_control_bench
`default_nettype wire
